// ==== rtl/cts_pkg.sv ====
// Shared constants and types for the transmit scheduler and bit-timing block.
`default_nettype none
package cts_pkg;
	// Three transmit buffers, four priority levels.
	localparam int NUM_BUF = 3;
	localparam int PRI_W = 2;
	localparam int BUF_W = 2;
	// Register byte offsets on the APB word map.
	localparam logic [7:0] ADDR_TXB0 = 8'h00, ADDR_STEP = 8'h04, ADDR_CTRL = 8'h0c;
	localparam logic [7:0] ADDR_INTF = 8'h10, ADDR_CFG1 = 8'h14, ADDR_CFG2 = 8'h18;
	localparam logic [7:0] ADDR_TEC = 8'h1c;
	// Transmit buffer control fields.
	localparam int TXC_PRI = 0, TXC_IE = 2, TXC_REQ = 3, TXC_ERR = 4, TXC_LARB = 5, TXC_ABT = 6;
	// Control register fields.
	localparam int CTRL_CKS = 11, CTRL_ABORT_ALL_REQUEST = 12;
	// Interrupt flag register fields; free flags occupy FREE .. FREE+2.
	localparam int INTF_FREE = 2, INTF_ERROR_INT_FLAG = 5, INTF_WAR = 10, INTF_EP = 12, INTF_BO = 13;
	// Bit timing fields.
	localparam int CFG1_BRP = 0, CFG1_SJW = 6;
	localparam int CFG2_PROP_SEGMENT_LEN = 0, CFG2_PH1 = 3, CFG2_SAM = 6, CFG2_PH2 = 8, CFG2_OK = 15;
	localparam int BRP_W = 6, SEG_W = 3, SJW_W = 2, CNT_W = 5;
	// Transmit error counter limits.
	localparam int TEC_W = 9;
	localparam logic [TEC_W-1:0] TEC_WARN = 9'h060, TEC_PASSIVE = 9'h07f, TEC_BUSOFF = 9'h0ff;
	localparam logic [TEC_W-1:0] TEC_SAT = 9'h1ff;
	// Module clock: REF_CLK is four instruction clocks; select divides by four.
	localparam logic [1:0] CKS_LAST = 2'h3;
	localparam int CAN_MODULE_CLOCK_MAX_MHZ = 30;
	// Nominal bit time bounds in quanta, and the one-quantum sync segment.
	localparam logic [CNT_W-1:0] BIT_TQ_MIN = 5'h08, BIT_TQ_MAX = 5'h19, TQ_ONE = 5'h01;
	typedef enum logic [1:0] {SCH_IDLE = 2'b01, SCH_BUSY = 2'b10} cts_sched_type;
	typedef enum logic [3:0] {
		SEG_SYNC = 4'b0001,
		SEG_PROP = 4'b0010,
		SEG_PH1 = 4'b0100,
		SEG_PH2 = 4'b1000
	} cts_seg_type;
endpackage
`default_nettype wire

// ==== rtl/cts_tx_arbiter.sv ====
// Picks the pending transmit buffer with the highest priority level.
`default_nettype none
module cts_tx_arbiter
	import cts_pkg::*;
(
	input wire logic [NUM_BUF-1:0] pending,
	input wire logic [NUM_BUF*PRI_W-1:0] prio,
	output logic any,
	output logic [BUF_W-1:0] sel
);
	logic [PRI_W-1:0] best;

	// Level 11 wins over 10 and 01, 00 loses; ties go to the higher index.
	always_comb
	begin
		any = 1'b0;
		sel = '0;
		best = '0;
		for (int i = 0; i < NUM_BUF; i++)
		begin
			if (pending[i] && (!any || prio[i*PRI_W +: PRI_W] >= best))
			begin
				any = 1'b1;
				sel = BUF_W'(i);
				best = prio[i*PRI_W +: PRI_W];
			end
		end
	end
endmodule
`default_nettype wire

// ==== rtl/cts_bit_timing.sv ====
// Nominal bit-time generator: prescaler, segments, sampling and synchronisation.
`default_nettype none
module cts_bit_timing
	import cts_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic mod_en,
	input wire logic [BRP_W-1:0] baud_prescaler,
	input wire logic [SEG_W-1:0] prop_segment_len,
	input wire logic [SEG_W-1:0] ph1,
	input wire logic [SEG_W-1:0] ph2,
	input wire logic [SJW_W-1:0] sync_jump_width,
	input wire logic triple_sample_sel,
	input wire logic bus_idle,
	input wire logic rx,
	output logic sample_stb,
	output logic bit_val,
	output logic bit_start
);
	logic [BRP_W:0] presc;
	logic tq_tick, half_tick, rx_q, fall, synced, maj, hard, resync, shorten;
	logic [1:0] hist;
	cts_seg_type seg;
	logic [CNT_W-1:0] seg_cnt, seg_len, cur_len, since, ph1_ext, jw, err_q;

	// One quantum is 2*(brp+1) module clocks; the half point feeds triple sampling.
	assign tq_tick = mod_en && presc == {baud_prescaler, 1'b1};
	assign half_tick = mod_en && presc == {1'b0, baud_prescaler};
	assign fall = rx_q && !rx;
	assign hard = fall && bus_idle;
	assign resync = fall && !bus_idle && !synced && seg != SEG_SYNC;
	assign jw = CNT_W'(sync_jump_width) + TQ_ONE;
	assign err_q = (since + TQ_ONE < jw) ? since + TQ_ONE : jw;
	assign maj = (rx & hist[0]) | (rx & hist[1]) | (hist[0] & hist[1]);

	// Prescaler restarts on a hard synchronisation edge.
	always_ff @(posedge clk)
	begin
		if (rst || hard || tq_tick)
			presc <= '0;
		else if (mod_en)
			presc <= presc + 1'b1;
	end

	// Bus history at half-quantum spacing, used for the majority vote.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_q <= 1'b1;
			hist <= 2'h3;
		end
		else
		begin
			rx_q <= rx;
			if (half_tick || tq_tick)
				hist <= {hist[0], rx};
		end
	end

	// Resync lengthens phase one or shortens phase two by at most the jump width.
	always_comb
	begin
		cur_len = seg_len;
		shorten = 1'b0;
		if (resync && seg == SEG_PH1)
			cur_len = seg_len + err_q;
		else if (resync && seg == SEG_PH2)
		begin
			if (seg_len - seg_cnt <= jw)
				shorten = 1'b1;
			else
				cur_len = seg_len - jw;
		end
	end

	// Segment sequencer; an edge in phase two within the jump width of its end starts the next bit at once.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			seg <= SEG_SYNC;
			seg_cnt <= '0;
			seg_len <= TQ_ONE;
			since <= '0;
			ph1_ext <= '0;
			synced <= 1'b0;
			sample_stb <= 1'b0;
			bit_val <= 1'b1;
			bit_start <= 1'b0;
		end
		else
		begin
			sample_stb <= 1'b0;
			bit_start <= 1'b0;
			if (hard || shorten)
			begin
				seg <= SEG_SYNC;
				seg_cnt <= '0;
				seg_len <= TQ_ONE;
				ph1_ext <= '0;
				synced <= 1'b1;
				bit_start <= 1'b1;
			end
			else
			begin
				if (resync)
					synced <= 1'b1;
				if (resync && seg == SEG_PROP)
					ph1_ext <= err_q;
				seg_len <= cur_len;
				if (tq_tick)
				begin
					since <= (seg == SEG_SYNC) ? '0 : since + TQ_ONE;
					seg_cnt <= seg_cnt + TQ_ONE;
					if (seg_cnt + TQ_ONE >= cur_len)
					begin
						seg_cnt <= '0;
						case (seg)
							SEG_SYNC:
							begin
								seg <= SEG_PROP;
								seg_len <= CNT_W'(prop_segment_len) + TQ_ONE;
							end
							SEG_PROP:
							begin
								seg <= SEG_PH1;
								seg_len <= CNT_W'(ph1) + TQ_ONE + ph1_ext;
							end
							SEG_PH1:
							begin
								seg <= SEG_PH2;
								seg_len <= CNT_W'(ph2) + TQ_ONE;
								sample_stb <= 1'b1;
								bit_val <= triple_sample_sel ? maj : rx;
							end
							default:
							begin
								seg <= SEG_SYNC;
								seg_len <= TQ_ONE;
								ph1_ext <= '0;
								synced <= 1'b0;
								bit_start <= 1'b1;
							end
						endcase
					end
				end
			end
		end
	end

	// A hard synchronisation edge puts the bit back to its sync segment.
	hard_sync_a: assert property (@(posedge clk) disable iff (rst)
		hard |=> seg == SEG_SYNC && synced && bit_start)
		else $error("hard sync did not restart the bit");
	// Quantum boundaries fall only at prescaler count 2*brp+1, with the module clock enabled.
	quantum_len_a: assert property (@(posedge clk) disable iff (rst)
		tq_tick |-> presc == {baud_prescaler, 1'b1} && mod_en)
		else $error("quantum tick off its prescaler count");
	sample_cov: cover property (@(posedge clk) disable iff (rst) sample_stb && triple_sample_sel);
endmodule
`default_nettype wire

// ==== rtl/cts_tx_sched.sv ====
// Transmit scheduler, error counting and bit-timing configuration with an APB slave.
// Functional notes
// - Two-bit priority per buffer: 11 highest, 10 and 01 middle, 00 lowest.
// - Setting a request clears that buffer's aborted, lost and error flags.
// - Request only queues; highest priority starts when bus idle, priority resolved first.
// - First-try success clears the request; free flag raised when enabled.
// - A failed attempt keeps the request; a bus error sets the error flag.
// - Lost arbitration sets the lost flag and raises no interrupt flag.
// - Abort by clearing one request or by the abort-all request bit.
// - Abort before start or after lost/error sets aborted, never the free flag.
// - Each acknowledge, form or bit error while sending adds exactly one.
// - Error count above 96 sets the error and warning flags.
// - Per-buffer free flags show which empty buffer can be loaded.
// - Error count above 127 enters error passive and sets its flag.
// - Error count above 255 enters bus off and sets its flag.
// - Bit time is sync, prop, phase one, phase two; 8 to 25 quanta.
// - One quantum is 2*(prescaler+1) module clocks.
// - Module clock is REF_CLK, or a quarter of it when clock select set.
// - Propagation segment is 1 to 8 quanta from a 3-bit field.
// - Phase one and phase two are 1 to 8 quanta each.
// - Sample at end of phase one; optional majority of three half-quantum samples.
// - Each incoming edge is compared to sync and phase segments adjusted. The code resyncs only on the first falling edge outside sync in each bit.
// - Adjustment limited to jump width 1..4 quanta; phase two exceeds it. The code does not check this; timing_ok only bounds the 8 to 25 quanta total.
// - Idle recessive-to-dominant edge hard-syncs and blocks resync that bit.
//
// Implementation choices: the address map and register access over APB.
`default_nettype none
module cts_tx_sched
	import cts_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic BUS_IDLE,
	input wire logic TX_DONE,
	input wire logic TX_LOST_ARB,
	input wire logic TX_ACK_ERR,
	input wire logic TX_FORM_ERR,
	input wire logic TX_BIT_ERR,
	input wire logic RX_IN,
	output logic TX_START,
	output logic [BUF_W-1:0] TX_BUF_SEL,
	output logic TX_ACTIVE,
	output logic BUS_OFF,
	output logic SAMPLE_STROBE,
	output logic SAMPLE_BIT,
	output logic BIT_START
);
	// Per-buffer control and status.
	logic [NUM_BUF*PRI_W-1:0] prio;
	logic [NUM_BUF-1:0] ie, req, err_f, larb, abt, abort_pend, free, txb_wr, sw_abort;
	// Control, timing configuration and error state.
	logic abort_all_request, cks, triple_sample_sel, war, ep, error_int_flag, timing_ok, mod_en;
	logic [BRP_W-1:0] baud_prescaler;
	logic [SJW_W-1:0] sync_jump_width;
	logic [SEG_W-1:0] prop_segment_len, ph1, ph2;
	logic [TEC_W-1:0] tec;
	logic [TEC_W:0] next_tec;
	logic [1:0] err_inc, cks_cnt;
	logic [CNT_W-1:0] bit_len;
	cts_sched_type state;
	logic arb_any, acc, wr, abort_all_request_go, intf_wr, start_now, bus_err, busy, fin;
	logic [BUF_W-1:0] arb_sel;
	logic [31:0] next_prdata;

	// One decode serves both the write strobes and the read mux.
	function automatic logic txb_hit(input logic [7:0] a, input int i);
		return a == (ADDR_TXB0 + 8'(i) * ADDR_STEP);
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		logic hit;
		hit = a == ADDR_CTRL || a == ADDR_INTF || a == ADDR_CFG1;
		hit = hit || a == ADDR_CFG2 || a == ADDR_TEC;
		for (int i = 0; i < NUM_BUF; i++)
			hit = hit || txb_hit(a, i);
		return hit;
	endfunction

	// Writes take effect only at the edge where the access phase meets PREADY.
	assign acc = PSEL && PENABLE && PREADY;
	assign wr = acc && PWRITE;
	assign abort_all_request_go = wr && PADDR == ADDR_CTRL && PWDATA[CTRL_ABORT_ALL_REQUEST];
	assign intf_wr = wr && PADDR == ADDR_INTF;
	assign busy = state == SCH_BUSY;
	assign bus_err = TX_ACK_ERR || TX_FORM_ERR || TX_BIT_ERR;
	assign fin = busy && (TX_DONE || TX_LOST_ARB || bus_err);
	assign err_inc = 2'(TX_ACK_ERR) + 2'(TX_FORM_ERR) + 2'(TX_BIT_ERR);

	// Abort requests: one buffer by clearing its request, or all at once.
	for (genvar i = 0; i < NUM_BUF; i++)
	begin : g_dec
		assign txb_wr[i] = wr && txb_hit(PADDR, i);
		assign sw_abort[i] = req[i] && ((txb_wr[i] && !PWDATA[TXC_REQ]) || abort_all_request_go);
	end

	// Every transfer gets exactly one wait state; the answer is registered.
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			PREADY <= 1'b0;
			PRDATA <= '0;
			PSLVERR <= 1'b0;
		end
		else
		begin
			PREADY <= PSEL && PENABLE && !PREADY;
			if (PSEL && PENABLE && !PREADY)
			begin
				PRDATA <= PWRITE ? '0 : next_prdata;
				PSLVERR <= !is_mapped(PADDR);
			end
		end
	end

	// Read mux; unmapped addresses and reserved bits read as zero.
	always_comb
	begin
		next_prdata = '0;
		case (PADDR)
			ADDR_CTRL:
			begin
				next_prdata[CTRL_CKS] = cks;
				next_prdata[CTRL_ABORT_ALL_REQUEST] = abort_all_request;
			end
			ADDR_INTF:
			begin
				next_prdata[INTF_FREE +: NUM_BUF] = free;
				next_prdata[INTF_ERROR_INT_FLAG] = error_int_flag;
				next_prdata[INTF_WAR] = war;
				next_prdata[INTF_EP] = ep;
				next_prdata[INTF_BO] = BUS_OFF;
			end
			ADDR_CFG1:
			begin
				next_prdata[CFG1_BRP +: BRP_W] = baud_prescaler;
				next_prdata[CFG1_SJW +: SJW_W] = sync_jump_width;
			end
			ADDR_CFG2:
			begin
				next_prdata[CFG2_PROP_SEGMENT_LEN +: SEG_W] = prop_segment_len;
				next_prdata[CFG2_PH1 +: SEG_W] = ph1;
				next_prdata[CFG2_SAM] = triple_sample_sel;
				next_prdata[CFG2_PH2 +: SEG_W] = ph2;
				next_prdata[CFG2_OK] = timing_ok;
			end
			ADDR_TEC: next_prdata[TEC_W-1:0] = tec;
			// Buffer words sit in the default branch so no other branch can touch their bits.
			default:
				for (int i = 0; i < NUM_BUF; i++)
				begin
					if (txb_hit(PADDR, i))
					begin
						next_prdata[TXC_PRI +: PRI_W] = prio[i*PRI_W +: PRI_W];
						next_prdata[TXC_IE] = ie[i];
						next_prdata[TXC_REQ] = req[i];
						next_prdata[TXC_ERR] = err_f[i];
						next_prdata[TXC_LARB] = larb[i];
						next_prdata[TXC_ABT] = abt[i];
					end
				end
		endcase
	end

	// Clock select and bit timing configuration.
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			cks <= 1'b0;
			baud_prescaler <= '0;
			sync_jump_width <= '0;
			prop_segment_len <= '0;
			ph1 <= '0;
			ph2 <= '0;
			triple_sample_sel <= 1'b0;
		end
		else
		begin
			if (wr && PADDR == ADDR_CTRL)
				cks <= PWDATA[CTRL_CKS];
			if (wr && PADDR == ADDR_CFG1)
			begin
				baud_prescaler <= PWDATA[CFG1_BRP +: BRP_W];
				sync_jump_width <= PWDATA[CFG1_SJW +: SJW_W];
			end
			if (wr && PADDR == ADDR_CFG2)
			begin
				prop_segment_len <= PWDATA[CFG2_PROP_SEGMENT_LEN +: SEG_W];
				ph1 <= PWDATA[CFG2_PH1 +: SEG_W];
				triple_sample_sel <= PWDATA[CFG2_SAM];
				ph2 <= PWDATA[CFG2_PH2 +: SEG_W];
			end
		end
	end

	// Buffer state; engine outcomes come after software so the engine wins a conflict.
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			prio <= '0;
			ie <= '0;
			req <= '0;
			err_f <= '0;
			larb <= '0;
			abt <= '0;
			abort_pend <= '0;
		end
		else
		begin
			for (int i = 0; i < NUM_BUF; i++)
			begin
				if (txb_wr[i])
				begin
					prio[i*PRI_W +: PRI_W] <= PWDATA[TXC_PRI +: PRI_W];
					ie[i] <= PWDATA[TXC_IE];
					if (PWDATA[TXC_REQ] && !req[i])
					begin
						req[i] <= 1'b1;
						err_f[i] <= 1'b0;
						larb[i] <= 1'b0;
						abt[i] <= 1'b0;
						abort_pend[i] <= 1'b0;
					end
				end
				if (sw_abort[i] && busy && TX_BUF_SEL == BUF_W'(i))
					abort_pend[i] <= 1'b1;
				else if (sw_abort[i])
				begin
					req[i] <= 1'b0;
					abt[i] <= 1'b1;
				end
				if (busy && TX_BUF_SEL == BUF_W'(i))
				begin
					if (TX_DONE)
					begin
						req[i] <= 1'b0;
						abort_pend[i] <= 1'b0;
					end
					else if (TX_LOST_ARB || bus_err)
					begin
						larb[i] <= larb[i] || TX_LOST_ARB;
						err_f[i] <= err_f[i] || bus_err;
						if (abort_pend[i] || sw_abort[i])
						begin
							req[i] <= 1'b0;
							abt[i] <= 1'b1;
							abort_pend[i] <= 1'b0;
						end
					end
				end
			end
		end
	end

	// Free flags: set on success when enabled, cleared by writing one.
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			free <= '0;
		else
			for (int i = 0; i < NUM_BUF; i++)
			begin
				if (intf_wr && PWDATA[INTF_FREE + i])
					free[i] <= 1'b0;
				if (busy && TX_DONE && TX_BUF_SEL == BUF_W'(i) && ie[i])
					free[i] <= 1'b1;
			end
	end

	// The abort-all bit reads back set until no abort waits on a frame.
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			abort_all_request <= 1'b0;
		else if (abort_all_request_go)
			abort_all_request <= 1'b1;
		else if (abort_pend == '0)
			abort_all_request <= 1'b0;
	end

	cts_tx_arbiter u_arb (
		.pending(req & ~abort_pend),
		.prio(prio),
		.any(arb_any),
		.sel(arb_sel)
	);

	// No start in a cycle with a register write, so a priority change lands first.
	assign start_now = state == SCH_IDLE && arb_any && BUS_IDLE && !BUS_OFF && !wr;

	// Scheduler: idle until a start, busy until the engine reports an outcome.
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			state <= SCH_IDLE;
			TX_START <= 1'b0;
			TX_BUF_SEL <= '0;
			TX_ACTIVE <= 1'b0;
		end
		else
		begin
			TX_START <= start_now;
			case (state)
				SCH_IDLE:
					if (start_now)
					begin
						state <= SCH_BUSY;
						TX_BUF_SEL <= arb_sel;
						TX_ACTIVE <= 1'b1;
					end
				SCH_BUSY:
					if (fin)
					begin
						state <= SCH_IDLE;
						TX_ACTIVE <= 1'b0;
					end
				default:
				begin
					state <= SCH_IDLE;
					TX_ACTIVE <= 1'b0;
				end
			endcase
		end
	end

	// The count saturates so the bus-off state cannot wrap back to active.
	assign next_tec = {1'b0, tec} + (TEC_W + 1)'(err_inc);
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			tec <= '0;
		else if (busy && bus_err)
			tec <= next_tec > {1'b0, TEC_SAT} ? TEC_SAT : next_tec[TEC_W-1:0];
	end

	// Error state flags follow the count; the summary flag is sticky.
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			war <= 1'b0;
			ep <= 1'b0;
			BUS_OFF <= 1'b0;
			error_int_flag <= 1'b0;
		end
		else
		begin
			war <= tec > TEC_WARN;
			ep <= tec > TEC_PASSIVE;
			BUS_OFF <= tec > TEC_BUSOFF;
			if (intf_wr && PWDATA[INTF_ERROR_INT_FLAG])
				error_int_flag <= 1'b0;
			if (tec > TEC_WARN && !war)
				error_int_flag <= 1'b1;
		end
	end

	// Module clock enable: every REF_CLK edge, or one in four when selected.
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			cks_cnt <= '0;
		else
			cks_cnt <= cks_cnt + 2'h1;
	end
	assign mod_en = !cks || cks_cnt == CKS_LAST;

	// Quanta per bit: sync plus three programmed segments of 1..8 each.
	assign bit_len = TQ_ONE * 5'h4 + CNT_W'(prop_segment_len) + CNT_W'(ph1) + CNT_W'(ph2);
	assign timing_ok = bit_len >= BIT_TQ_MIN && bit_len <= BIT_TQ_MAX;

	cts_bit_timing u_bt (
		.clk(REF_CLK),
		.rst(RST),
		.mod_en(mod_en && timing_ok),
		.baud_prescaler(baud_prescaler),
		.prop_segment_len(prop_segment_len),
		.ph1(ph1),
		.ph2(ph2),
		.sync_jump_width(sync_jump_width),
		.triple_sample_sel(triple_sample_sel),
		.bus_idle(BUS_IDLE),
		.rx(RX_IN),
		.sample_stb(SAMPLE_STROBE),
		.bit_val(SAMPLE_BIT),
		.bit_start(BIT_START)
	);

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	req_clears_a: assert property (txb_wr[0] && PWDATA[TXC_REQ] && !req[0] && !busy
		|=> req[0] && !err_f[0] && !larb[0] && !abt[0])
		else $error("setting a request left old flags");
	start_sel_a: assert property (start_now |=> TX_START && TX_BUF_SEL == $past(arb_sel)
		##1 !TX_START)
		else $error("start pulse or buffer choice wrong");
	done_clears_a: assert property (busy && TX_DONE |=> !req[TX_BUF_SEL] && !busy)
		else $error("success left request set");
	err_keeps_a: assert property (busy && bus_err && !TX_DONE && abort_pend == '0 && !wr
		|=> req[TX_BUF_SEL] && err_f[TX_BUF_SEL])
		else $error("failed attempt lost its request");
	lost_quiet_a: assert property (busy && TX_LOST_ARB && !bus_err && !TX_DONE
		|=> larb[TX_BUF_SEL] && $stable(free) && $stable(error_int_flag))
		else $error("lost arbitration raised a flag");
	abort_idle_a: assert property (txb_wr[1] && !PWDATA[TXC_REQ] && req[1] && !busy
		|=> !req[1] && abt[1] && $stable(free))
		else $error("abort of an idle buffer not processed");
	tec_step_a: assert property (busy && $onehot({TX_ACK_ERR, TX_FORM_ERR, TX_BIT_ERR})
		&& tec != TEC_SAT |=> tec == $past(tec) + 9'h001)
		else $error("error count did not step by one");
	warn_a: assert property (tec > TEC_WARN && !war |=> war && error_int_flag)
		else $error("warning limit missed");
	passive_off_a: assert property (tec > TEC_BUSOFF |=> ep && BUS_OFF ##1 !TX_START)
		else $error("bus off not entered or still starting");
	start_cov: cover property (TX_START ##[1:20] TX_DONE);
	lost_cov: cover property (busy && TX_LOST_ARB);
	abort_cov: cover property (abort_all_request_go && busy);
endmodule
`default_nettype wire

// ==== tb/cts_node_model.sv ====
// Behavioural stand-in for the protocol engine and the other nodes on the bus.
`default_nettype none
module cts_node_model (
	input wire logic clk,
	input wire logic start,
	input wire logic [2:0] mode,
	input wire logic [3:0] dly,
	output var logic done = 1'b0,
	output var logic lost = 1'b0,
	output var logic ack_err = 1'b0,
	output var logic form_err = 1'b0,
	output var logic bit_err = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] cnt = 5'h00;
	logic fire;
	assign fire = cnt == 5'h01;
	// Each frame in modes 0 to 4 gets exactly one outcome pulse, dly+2 cycles after the edge that samples its start.
	// A late outcome shows whether the block waits patiently for the engine.
	always_ff @(posedge clk)
	begin
		cnt <= start ? {1'b0, dly} + 5'h02 : (cnt != 5'h00 ? cnt - 5'h01 : cnt);
		done <= fire && mode == 3'h0;
		lost <= fire && mode == 3'h1;
		ack_err <= fire && mode == 3'h2;
		form_err <= fire && mode == 3'h3;
		bit_err <= fire && mode == 3'h4;
	end
endmodule
`default_nettype wire

// ==== tb/cts_tx_sched_tb_top.sv ====
// Self-checking bench for the transmit scheduler and bit-timing block.
`default_nettype none
module cts_tx_sched_tb_top
	import cts_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, idle = 1'b0;
	logic rx = 1'b1;
	logic sbit, bstart;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, q, prdata;
	logic [2:0] mode = 3'h0;
	logic [3:0] dly = 4'h1;
	logic err, done, lost, ackerr, formerr, biterr, start, active, ready, slverr, busoff, strobe;
	logic [1:0] sel;
	int n_fail = 0;
	int check_count = 0;
	cts_tx_sched uut (.REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(ready),
		.PSLVERR(slverr), .BUS_IDLE(idle), .TX_DONE(done), .TX_LOST_ARB(lost),
		.TX_ACK_ERR(ackerr), .TX_FORM_ERR(formerr), .TX_BIT_ERR(biterr), .RX_IN(rx),
		.TX_START(start), .TX_BUF_SEL(sel), .TX_ACTIVE(active), .BUS_OFF(busoff),
		.SAMPLE_STROBE(strobe), .SAMPLE_BIT(sbit), .BIT_START(bstart));
	cts_node_model node (.clk(clk), .start(start), .mode(mode), .dly(dly), .done(done),
		.lost(lost), .ack_err(ackerr), .form_err(formerr), .bit_err(biterr));
	// The 200 MHz module clock.
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer; the leading edge keeps a release and a new setup apart.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the slave.
		do
			@(posedge clk);
		while (ready !== 1'b1);
		q = prdata;
		err = slverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Opens the bus for one frame, closes it after the start and waits for the outcome.
	task automatic frame(input logic [2:0] m, output logic [1:0] s);
		mode <= m;
		idle <= 1'b1;
		do
			@(posedge clk);
		while (start !== 1'b1);
		s = sel;
		idle <= 1'b0;
		while (active !== 1'b0)
			@(posedge clk);
	endtask
	task automatic close_out;
		$display("Checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Reset contents and an unmapped address.
	task automatic t_reset;
		apb(1'b0, ADDR_TXB0, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, 8'hfc, 32'h0);
		chk({q[30:0], err}, 32'h1);
	endtask
	// A 9-quantum bit at prescaler 0 puts strobes 18 clocks apart.
	task automatic t_timing;
		int n;
		apb(1'b1, ADDR_CFG1, 32'h0);
		apb(1'b1, ADDR_CFG2, 32'h112);
		apb(1'b0, ADDR_CFG2, 32'h0);
		chk(q, 32'h8112);
		repeat (3)
		begin
			n = 0;
			do
			begin
				@(posedge clk);
				n++;
			end
			while (strobe !== 1'b1 && n < 100);
		end
		chk(n, 18);
		// An idle falling edge restarts the bit; sync, prop and phase one take 14 clocks.
		apb(1'b1, ADDR_CFG2, 32'h152);
		idle <= 1'b1;
		rx <= 1'b0;
		@(posedge clk);
		@(posedge clk);
		chk(bstart, 1);
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (strobe !== 1'b1);
		chk(n, 14);
		chk(sbit, 0);
		rx <= 1'b1;
		idle <= 1'b0;
	endtask
	task automatic t_prio;
		logic [1:0] s;
		apb(1'b1, ADDR_TXB0, 32'h9);
		apb(1'b1, ADDR_TXB0 + ADDR_STEP, 32'hb);
		apb(1'b1, ADDR_TXB0 + 8'h08, 32'hf);
		frame(3'h0, s);
		chk(s, 2);
		apb(1'b0, ADDR_TXB0 + 8'h08, 32'h0);
		chk(q, 32'h7);
		apb(1'b0, ADDR_INTF, 32'h0);
		chk(q[4:2], 3'h4);
		dly <= 4'h9;
		frame(3'h1, s);
		chk(s, 1);
		apb(1'b0, ADDR_TXB0 + ADDR_STEP, 32'h0);
		chk(q, 32'h2b);
		apb(1'b0, ADDR_INTF, 32'h0);
		chk(q[5:2], 4'h4);
		apb(1'b1, ADDR_TXB0 + ADDR_STEP, 32'h3);
		apb(1'b0, ADDR_TXB0 + ADDR_STEP, 32'h0);
		chk(q, 32'h63);
		apb(1'b1, ADDR_CTRL, 32'h1000);
		apb(1'b0, ADDR_TXB0, 32'h0);
		chk(q, 32'h41);
		apb(1'b1, ADDR_TXB0 + ADDR_STEP, 32'hb);
		apb(1'b0, ADDR_TXB0 + ADDR_STEP, 32'h0);
		chk(q, 32'hb);
	endtask
	// Failed frames cycle through the three error kinds up to bus off.
	task automatic t_err;
		logic [1:0] s;
		for (int k = 1; k <= 256; k++)
		begin
			frame(3'(2 + k % 3), s);
			if (k == 1 || k == 96 || k == 97 || k == 127 || k == 128 || k >= 255)
			begin
				apb(1'b0, ADDR_TEC, 32'h0);
				chk(q, k);
				apb(1'b0, ADDR_INTF, 32'h0);
				chk({q[INTF_BO], q[INTF_EP], q[INTF_WAR], q[INTF_ERROR_INT_FLAG]},
					{k > 255, k > 127, k > 96, k > 96});
			end
		end
		apb(1'b0, ADDR_TXB0 + ADDR_STEP, 32'h0);
		chk(q, 32'h1b);
		chk(busoff, 1);
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_timing();
		t_prio();
		t_err();
		close_out();
	end
	// Watchdog at 20000 clocks, about five times the expected run length.
	initial
	begin
		#100000;
		n_fail++;
		close_out();
	end
endmodule
`default_nettype wire
